// File: design/dac_reference_control.sv
// APB register slave and control decode for a 5-bit reference converter.
// Assumes a same-clock APB master; the analog ladder sits outside this module.
// The analog side samples analogCtrl as plain levels; it sees no strobe.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module dac_reference_control
    import dac_reference_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire apb_req_s     apbReq,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    output analog_ctrl_s      analogCtrl
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]   controlMain;
    logic [7:0]   levelSelect;
    logic [7:0]   next_controlMain;
    logic [7:0]   next_levelSelect;
    logic [31:0]  next_prdata;
    logic         next_pslverr;
    analog_ctrl_s next_analogCtrl;
    logic         accessPhase;
    logic         hitMain;
    logic         hitLevel;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // A disabled converter must not leak any selection to the analog side.
    function automatic logic gateOn(input logic enable, input logic field);
        return enable & field;
    endfunction : gateOn

    // Only the implemented bits of a written byte are kept, so the rest read zero.
    function automatic logic [7:0] keepImplemented(input logic [7:0] data, input logic [7:0] mask);
        return data & mask;
    endfunction : keepImplemented

    // Registers are eight bits wide and sit in the low byte of the bus word.
    function automatic logic [31:0] toBusWord(input logic [7:0] value);
        return {24'h00_0000, value};
    endfunction : toBusWord

    // ------------------------------------------------------------------
    // Bus decode and register update
    // ------------------------------------------------------------------
    // Every access completes in its first access cycle, so pready is constant high.
    assign pready      = 1'b1;
    assign accessPhase = apbReq.psel && apbReq.penable;
    assign hitMain     = apbReq.paddr == DAC_CONTROL_MAIN_ADDR;
    assign hitLevel    = apbReq.paddr == DAC_LEVEL_SELECT_ADDR;

    always_comb begin
        next_controlMain = controlMain;
        next_levelSelect = levelSelect;
        next_prdata      = 32'h0000_0000;
        next_pslverr     = 1'b0;
        if (accessPhase && apbReq.pwrite && hitMain) begin
            next_controlMain = keepImplemented(apbReq.pwdata[7:0], CONTROL_MAIN_MASK);
        end
        if (accessPhase && apbReq.pwrite && hitLevel) begin
            next_levelSelect = keepImplemented(apbReq.pwdata[7:0], LEVEL_SELECT_MASK);
        end
        // Read data is registered for the cycle after setup so it is valid in access.
        if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
            if (hitMain) begin
                next_prdata = toBusWord(controlMain);
            end else if (hitLevel) begin
                next_prdata = toBusWord(levelSelect);
            end
        end
        if (apbReq.psel && !apbReq.penable && !hitMain && !hitLevel) begin
            next_pslverr = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Analog control decode
    // ------------------------------------------------------------------
    always_comb begin
        // Gating on the enable keeps the ladder idle so a disabled part draws no current.
        next_analogCtrl.ladderOn             = next_controlMain[CONVERTER_ON_BIT];
        next_analogCtrl.levelCode            = next_controlMain[CONVERTER_ON_BIT]
                                               ? next_levelSelect[LEVEL_CODE_WIDTH-1:0]
                                               : '0;
        next_analogCtrl.positiveSourceSelect = gateOn(next_controlMain[CONVERTER_ON_BIT],
                                                      next_controlMain[POSITIVE_SOURCE_SEL_BIT]);
        next_analogCtrl.pinOneDriveOn        = gateOn(next_controlMain[CONVERTER_ON_BIT],
                                                      next_controlMain[PIN_ONE_DRIVE_ON_BIT]);
        next_analogCtrl.pinTwoDriveOn        = gateOn(next_controlMain[CONVERTER_ON_BIT],
                                                      next_controlMain[PIN_TWO_DRIVE_ON_BIT]);
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    // The decode reads the next register values, so the analog controls change
    // at the very edge that takes the write and never lag the register by a cycle.

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            controlMain <= CONTROL_MAIN_RESET;
            levelSelect <= LEVEL_SELECT_RESET;
            prdata      <= 32'h0000_0000;
            pslverr     <= 1'b0;
            analogCtrl  <= '0;
        end else begin
            controlMain <= next_controlMain;
            levelSelect <= next_levelSelect;
            prdata      <= next_prdata;
            pslverr     <= next_pslverr;
            analogCtrl  <= next_analogCtrl;
        end
    end

    // ------------------------------------------------------------------
    // Assertions: register storage
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Write checks look one edge after the access phase, where the write lands.
    a_main_reserved_zero: assert property ((controlMain & ~CONTROL_MAIN_MASK) == 8'h00)
        else $error("reserved main bits set");
    a_level_reserved_zero: assert property ((levelSelect & ~LEVEL_SELECT_MASK) == 8'h00)
        else $error("reserved level bits set");
    a_main_write_lands: assert property (accessPhase && apbReq.pwrite && hitMain
        |=> controlMain == ($past(apbReq.pwdata[7:0]) & CONTROL_MAIN_MASK))
        else $error("main write did not land");
    a_level_write_lands: assert property (accessPhase && apbReq.pwrite && hitLevel
        |=> levelSelect == ($past(apbReq.pwdata[7:0]) & LEVEL_SELECT_MASK))
        else $error("level write did not land");
    a_stray_write_ignored: assert property (accessPhase && apbReq.pwrite && !hitMain && !hitLevel
        |=> $stable(controlMain) && $stable(levelSelect))
        else $error("unmapped write changed a register");
    a_idle_holds_level: assert property (!(accessPhase && apbReq.pwrite) |=> $stable(levelSelect))
        else $error("level changed without a write");

    // ------------------------------------------------------------------
    // Assertions: analog decode
    // ------------------------------------------------------------------
    // The decode is registered, so the outputs are compared with the register
    // state of the same cycle; only a_level_write_code checks the written bus data.
    a_level_write_code: assert property (accessPhase && apbReq.pwrite && hitLevel && controlMain[7]
        |=> analogCtrl.levelCode == $past(apbReq.pwdata[4:0]))
        else $error("level code not updated by write");
    a_enable_follows_bit: assert property (analogCtrl.ladderOn == controlMain[CONVERTER_ON_BIT])
        else $error("ladder enable mismatch");
    a_pin_one_drive: assert property (analogCtrl.pinOneDriveOn == (controlMain[7] && controlMain[5]))
        else $error("pin one drive mismatch");
    a_pin_two_drive: assert property (analogCtrl.pinTwoDriveOn == (controlMain[7] && controlMain[4]))
        else $error("pin two drive mismatch");
    a_source_select: assert property (analogCtrl.positiveSourceSelect == (controlMain[7] && controlMain[2]))
        else $error("source select mismatch");
    a_level_thirtytwo: assert property (controlMain[7] |-> analogCtrl.levelCode == levelSelect[4:0])
        else $error("level code differs from field");
    a_disabled_idle: assert property (!controlMain[7] |-> analogCtrl == '0)
        else $error("analog controls active while disabled");

    // ------------------------------------------------------------------
    // Assertions: bus response
    // ------------------------------------------------------------------
    // Read data is launched at the setup edge and must stand through the access phase.
    a_ready_always: assert property (pready)
        else $error("ready dropped");
    a_read_back_main: assert property (apbReq.psel && !apbReq.penable && !apbReq.pwrite && hitMain
        |=> prdata == toBusWord($past(controlMain)))
        else $error("main read data wrong");
    a_read_back_level: assert property (apbReq.psel && !apbReq.penable && !apbReq.pwrite && hitLevel
        |=> prdata == toBusWord($past(levelSelect)))
        else $error("level read data wrong");
    a_stray_read_error: assert property (apbReq.psel && !apbReq.penable && !hitMain && !hitLevel
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (apbReq.psel && !apbReq.penable && (hitMain || hitLevel)
        |=> !pslverr)
        else $error("error raised on a mapped register");
    a_upper_bytes_zero: assert property (prdata[31:8] == 24'h00_0000)
        else $error("upper read bytes not zero");

    // ------------------------------------------------------------------
    // Assertions: reset
    // ------------------------------------------------------------------
    // These run with the reset disable switched off, because the reset itself is the subject.
    a_reset_zero: assert property (@(posedge ref_clk) disable iff (1'b0)
        $rose(rst_n) |-> controlMain == 8'h00 && levelSelect == 8'h00)
        else $error("registers not zero after reset");
    a_reset_outputs: assert property (@(posedge ref_clk) disable iff (1'b0)
        $rose(rst_n) |-> analogCtrl == '0 && prdata == 32'h0000_0000 && !pslverr)
        else $error("outputs not idle after reset");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    c_enable_on: cover property ($rose(analogCtrl.ladderOn));
    c_both_pins: cover property (analogCtrl.pinOneDriveOn && analogCtrl.pinTwoDriveOn);
    c_top_level: cover property (analogCtrl.levelCode == 5'h1F);
    c_bad_addr: cover property (pslverr);
    c_source_external: cover property (analogCtrl.positiveSourceSelect);

endmodule : dac_reference_control
`default_nettype wire

// File: design/dac_reference_pkg.sv
// Package for the 5-bit reference converter control block.
// Assumes an APB slave with 32-bit data; registers are 8 bits wide in the low byte.
package dac_reference_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] DAC_CONTROL_MAIN_ADDR = 12'h000;
    localparam logic [11:0] DAC_LEVEL_SELECT_ADDR = 12'h004;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CONVERTER_ON_BIT          = 7;
    localparam int PIN_ONE_DRIVE_ON_BIT      = 5;
    localparam int PIN_TWO_DRIVE_ON_BIT      = 4;
    localparam int POSITIVE_SOURCE_SEL_BIT   = 2;
    localparam int LEVEL_CODE_WIDTH          = 5;
    localparam logic [7:0] CONTROL_MAIN_MASK = 8'hB4;
    localparam logic [7:0] LEVEL_SELECT_MASK = 8'h1F;
    localparam logic [7:0] CONTROL_MAIN_RESET = 8'h00;
    localparam logic [7:0] LEVEL_SELECT_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic                        ladderOn;
        logic [LEVEL_CODE_WIDTH-1:0] levelCode;
        logic                        positiveSourceSelect;
        logic                        pinOneDriveOn;
        logic                        pinTwoDriveOn;
    } analog_ctrl_s;

endpackage : dac_reference_pkg

// File: tb/tb_dac_reference_control.sv
// Self-checking bench for the reference converter control block.
// Assumes the package and the design are compiled first; the bench is the only APB master.
`timescale 1ns/1ps
`default_nettype none
module tb_dac_reference_control
    import dac_reference_pkg::*;
;
    logic         ref_clk   = 1'b0;
    logic         rst_n     = 1'b0;
    apb_req_s     apbReq    = '0;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    analog_ctrl_s analogCtrl;
    logic [31:0]  rdQ;
    logic         errQ;
    logic [31:0]  rd;
    logic         er;
    int           err_total = 0;
    int           checked   = 0;

    always #10 ref_clk = ~ref_clk;
    // Answer is captured at the completing edge itself, before that edge's updates land.
    always @(posedge ref_clk) begin
        rdQ  <= prdata;
        errQ <= pslverr;
    end

    dac_reference_control dac_reference_control_inst (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .apbReq     (apbReq),
        .pready     (pready),
        .prdata     (prdata),
        .pslverr    (pslverr),
        .analogCtrl (analogCtrl)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge ref_clk);
        apbReq.psel    <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite  <= wr;
        apbReq.paddr   <= addr;
        apbReq.pwdata  <= wdata;
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
        @(negedge ref_clk);
        rd = rdQ;
        er = errQ;
    endtask : apb

    // Expected analog controls: all inactive while the converter is off.
    function automatic logic [31:0] ana(input logic [7:0] m, input logic [7:0] l);
        return m[7] ? {23'h0, 1'b1, l[4:0], m[2], m[5], m[4]} : 32'h0;
    endfunction : ana

    task automatic setAndCheck(input logic [7:0] m, input logic [7:0] l);
        apb(1'b1, 12'h000, {24'h0, m});
        apb(1'b1, 12'h004, {24'h0, l});
        apb(1'b0, 12'h000, 32'h0);
        check(rd, {24'h0, m & 8'hB4});
        apb(1'b0, 12'h004, 32'h0);
        check(rd, {24'h0, l & 8'h1F});
        check(32'(analogCtrl), ana(m, l));
    endtask : setAndCheck

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        logic [7:0] mains [6] = '{8'hFF, 8'h84, 8'hA0, 8'h90, 8'h7F, 8'hB4};
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0);
        check(32'(analogCtrl), 32'h0);
        $display("test reset values done");
        foreach (mains[i]) setAndCheck(mains[i], 8'h15);
        $display("test main control fields done");
        for (int c = 0; c < 32; c++) setAndCheck(8'h80, {3'b111, 5'(c)});
        $display("test all level codes done");
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h80);
        $display("test unmapped address done");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0);
        check(32'(analogCtrl), 32'h0);
        $display("test mid-run reset done");
        test_done();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        test_done();
    end
endmodule : tb_dac_reference_control
`default_nettype wire
